// File: verilog/i2c_host_engine.sv
`timescale 1ns/10ps
// Summary of operation
// - buffer write after start shifts msb first
// - sample ack, flag after ninth clock
// - flag when stop or restart completes
// - receive request only honoured when idle
// - receive toggles scl each rollover, shifts sda
// - eighth fall: load buffer, flag, idle
// - full set on load, cleared on read
// - overrun when byte lands while full
// - buffer write while busy discarded, clash flag
// - ack sequence drives ack data, scl low
// - ack: wait, release scl, wait, low
// - stop: sda low, count, scl, sda release
// - stop seen sets flag, then irq
// - reset disables module, abandons transfer
// - start/stop flags cleared by reset, disable
// - stop by other host raises irq
// - released sda read low: arbitration lost
// - tx collision: stop, clear full, release
// - sequence collision: abort, clear enables
// - after loss keep watching for stop
// - next write restarts from first bit
// - start: sda low after period, flag, hold
// - ack status low on ack, high nack
// - divider reloads, counts down to zero
module i2c_host_engine (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_b,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_b,
  output logic             irq_flag
);
  import i2c_host_pkg::*;

  rate_if rate ();
  rate_divider u_div (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .rate    (rate)
  );

  engine_state_e state_q;
  logic [7:0]    buf_q, shift_q, reload_q;
  logic [3:0]    bit_q;
  logic [7:0]    ctl_q;
  logic          full_q, beg_flag_q, halt_flag_q, ackst_q, ovr_q, clash_q, irq_q, arb_q;
  logic          sda_low_q, scl_low_q, ack_q;
  logic          sda_m_q, sda_s_q, scl_m_q, scl_s_q, sda_p_q, scl_p_q;

  // pin synchronisers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      sda_p_q <= 1'b1;
      scl_p_q <= 1'b1;
    end else begin
      sda_m_q <= sda_i;
      sda_s_q <= sda_m_q;
      scl_m_q <= scl_i;
      scl_s_q <= scl_m_q;
      sda_p_q <= sda_s_q;
      scl_p_q <= scl_s_q;
    end
  end

  // bus access decode
  logic wb_req, wr, rd, wr_buf, wr_rel, wr_ctl, rd_buf, enabled, busy, tick;
  assign wb_req  = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr      = wb_req && wb_we_i && wb_sel_i[0];
  assign rd      = wb_req && !wb_we_i;
  assign wr_buf  = wr && (wb_adr_i == ADR_BUFFER);
  assign wr_rel  = wr && (wb_adr_i == ADR_RELOAD);
  assign wr_ctl  = wr && (wb_adr_i == ADR_CONTROL);
  assign rd_buf  = rd && (wb_adr_i == ADR_BUFFER);
  assign enabled = ctl_q[CTL_ENABLE];
  assign busy    = (state_q != ST_IDLE);
  assign tick    = rate.tick;

  // bus events seen on synchronised lines
  logic stop_seen, start_seen, sda_miss, buf_ok;
  assign stop_seen  = scl_s_q && scl_p_q && sda_s_q && !sda_p_q;
  assign start_seen = scl_s_q && scl_p_q && !sda_s_q && sda_p_q;
  // released sda read low while scl high
  assign sda_miss   = !sda_low_q && scl_s_q && !sda_s_q &&
                      (state_q == ST_TX_HIGH || state_q == ST_ACK_HIGH);
  assign buf_ok     = enabled && (state_q == ST_IDLE) && beg_flag_q;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_q    <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      ack_q <= wb_req;
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          ADR_BUFFER:  wb_dat_o <= {24'h00_0000, buf_q};
          ADR_RELOAD:  wb_dat_o <= {24'h00_0000, reload_q};
          ADR_CONTROL: wb_dat_o <= {24'h00_0000, ctl_q};
          ADR_STATUS:  wb_dat_o <= {24'h00_0000, arb_q, irq_q, clash_q, ovr_q,
                                    ackst_q, halt_flag_q, beg_flag_q, full_q};
          default:     wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end
  assign wb_ack_o = ack_q;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      reload_q <= RELOAD_RESET;
    end else if (wr_rel) begin
      reload_q <= wb_dat_i[7:0];
    end
  end

  // divider control
  logic run_d, reload_d;
  always_comb begin
    run_d    = 1'b0;
    reload_d = 1'b0;
    case (state_q)
      ST_IDLE:     run_d = 1'b0;
      ST_TX_HIGH, ST_ACKIN_HIGH, ST_RX_HIGH, ST_ACK_HIGH, ST_RPT_SCLHI: begin
        // clock arbitration: stretched scl holds divider
        run_d    = scl_s_q;
        reload_d = !scl_s_q;
      end
      ST_HALT_SDA: begin
        run_d    = !sda_s_q;
        reload_d = sda_s_q;
      end
      ST_HALT_SCL: run_d = 1'b1;
      ST_HALT_REL: begin
        run_d    = scl_s_q;
        reload_d = !scl_s_q;
      end
      default:     run_d = 1'b1;
    endcase
  end
  assign rate.run          = run_d;
  assign rate.reload       = reload_d;
  assign rate.reload_value = reload_q;

  // main sequencer
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q   <= ST_IDLE;
      sda_low_q <= 1'b0;
      scl_low_q <= 1'b0;
      bit_q     <= 4'h0;
      shift_q   <= BYTE_ZERO;
    end else if (!enabled || arb_q && busy) begin
      state_q   <= ST_IDLE;
      sda_low_q <= 1'b0;
      scl_low_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (wr_buf && buf_ok) begin
            shift_q   <= wb_dat_i[7:0];
            bit_q     <= BITS_PER_BYTE;
            sda_low_q <= !wb_dat_i[7];
            scl_low_q <= 1'b1;
            state_q   <= ST_TX_LOW;
          end else if (ctl_q[CTL_BEGIN]) begin
            state_q <= ST_BEG_WAIT;
          end else if (ctl_q[CTL_REPEAT]) begin
            scl_low_q <= 1'b1;
            state_q   <= ST_RPT_LOW;
          end else if (ctl_q[CTL_HALT]) begin
            sda_low_q <= 1'b1;
            state_q   <= ST_HALT_SDA;
          end else if (ctl_q[CTL_RECEIVE]) begin
            sda_low_q <= 1'b0;
            scl_low_q <= 1'b1;
            bit_q     <= 4'h0;
            state_q   <= ST_RX_LOW;
          end else if (ctl_q[CTL_ACKSEQ]) begin
            scl_low_q <= 1'b1;
            sda_low_q <= !ctl_q[CTL_ACKDATA];
            state_q   <= ST_ACK_LOW;
          end
        end
        ST_BEG_WAIT: if (tick) begin
          sda_low_q <= 1'b1;
          state_q   <= ST_BEG_HOLD;
        end
        ST_BEG_HOLD: if (tick) begin
          scl_low_q <= 1'b1;
          state_q   <= ST_IDLE;
        end
        ST_RPT_LOW: if (tick) begin
          sda_low_q <= 1'b0;
          state_q   <= ST_RPT_SDAHI;
        end
        ST_RPT_SDAHI: if (tick) begin
          scl_low_q <= 1'b0;
          state_q   <= ST_RPT_SCLHI;
        end
        ST_RPT_SCLHI: if (tick) begin
          sda_low_q <= 1'b1;
          state_q   <= ST_RPT_HOLD;
        end
        ST_RPT_HOLD: if (tick) begin
          scl_low_q <= 1'b1;
          state_q   <= ST_RPT_END;
        end
        ST_RPT_END: state_q <= ST_IDLE;
        ST_TX_LOW: if (tick) begin
          scl_low_q <= 1'b0;
          state_q   <= ST_TX_HIGH;
        end
        ST_TX_HIGH: if (tick) begin
          scl_low_q <= 1'b1;
          shift_q   <= {shift_q[6:0], 1'b0};
          bit_q     <= bit_q - 4'h1;
          if (bit_q == 4'h1) begin
            sda_low_q <= 1'b0;
            state_q   <= ST_ACKIN_LOW;
          end else begin
            sda_low_q <= !shift_q[6];
            state_q   <= ST_TX_LOW;
          end
        end
        ST_ACKIN_LOW: if (tick) begin
          scl_low_q <= 1'b0;
          state_q   <= ST_ACKIN_HIGH;
        end
        ST_ACKIN_HIGH: if (tick) begin
          scl_low_q <= 1'b1;
          state_q   <= ST_IDLE;
        end
        ST_RX_LOW: if (tick) begin
          scl_low_q <= 1'b0;
          state_q   <= ST_RX_HIGH;
        end
        ST_RX_HIGH: if (tick) begin
          scl_low_q <= 1'b1;
          shift_q   <= {shift_q[6:0], sda_s_q};
          bit_q     <= bit_q + 4'h1;
          state_q   <= (bit_q == 4'h7) ? ST_IDLE : ST_RX_LOW;
        end
        ST_ACK_LOW: if (tick) begin
          scl_low_q <= 1'b0;
          state_q   <= ST_ACK_HIGH;
        end
        ST_ACK_HIGH: if (tick) begin
          scl_low_q <= 1'b1;
          state_q   <= ST_IDLE;
        end
        ST_HALT_SDA: if (tick) begin
          scl_low_q <= 1'b0;
          state_q   <= ST_HALT_SCL;
        end
        ST_HALT_SCL: if (tick) begin
          sda_low_q <= 1'b0;
          state_q   <= ST_HALT_REL;
        end
        ST_HALT_REL: if (stop_seen) begin
          state_q <= ST_HALT_END;
        end
        ST_HALT_END: if (tick) begin
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  logic rx_done, tx_ack_done, seq_done;
  assign rx_done     = enabled && state_q == ST_RX_HIGH && tick && bit_q == 4'h7;
  assign tx_ack_done = enabled && state_q == ST_ACKIN_HIGH && tick;
  assign seq_done    = enabled && tick && (state_q == ST_HALT_END || state_q == ST_BEG_HOLD ||
                       state_q == ST_ACK_HIGH) || enabled && state_q == ST_RPT_END;

  // control register, go bits cleared by hardware
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl_q <= BYTE_ZERO;
    end else if (wr_ctl) begin
      ctl_q <= wb_dat_i[7:0];
    end else if (!enabled || arb_q && busy) begin
      ctl_q[4:0] <= 5'h00;
    end else begin
      if (state_q == ST_BEG_HOLD && tick) ctl_q[CTL_BEGIN] <= 1'b0;
      if (state_q == ST_RPT_END) ctl_q[CTL_REPEAT] <= 1'b0;
      if (state_q == ST_HALT_END && tick) ctl_q[CTL_HALT] <= 1'b0;
      if (rx_done) ctl_q[CTL_RECEIVE] <= 1'b0;
      if (state_q == ST_ACK_HIGH && tick) ctl_q[CTL_ACKSEQ] <= 1'b0;
      if (busy && !(state_q == ST_RX_LOW || state_q == ST_RX_HIGH))
        ctl_q[CTL_RECEIVE] <= 1'b0;
    end
  end

  // transfer buffer, buffer full, overrun, clash
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      buf_q   <= BYTE_ZERO;
      full_q  <= 1'b0;
      ovr_q   <= 1'b0;
      clash_q <= 1'b0;
      ackst_q <= 1'b0;
    end else begin
      if (rx_done) begin
        buf_q  <= {shift_q[6:0], sda_s_q};
        full_q <= 1'b1;
        if (full_q && !rd_buf) ovr_q <= 1'b1;
      end else if (wr_buf && buf_ok) begin
        buf_q  <= wb_dat_i[7:0];
        full_q <= 1'b1;
      end else if (rd_buf || arb_q || state_q == ST_TX_HIGH && tick && bit_q == 4'h1) begin
        full_q <= 1'b0;
      end
      if (wr_buf && !buf_ok) clash_q <= 1'b1;
      else if (wr && wb_adr_i == ADR_STATUS && !wb_dat_i[ST_WRITE_CLASH]) clash_q <= 1'b0;
      if (wr && wb_adr_i == ADR_STATUS && !wb_dat_i[ST_OVERRUN] && !rx_done) ovr_q <= 1'b0;
      if (state_q == ST_ACKIN_HIGH && tick) ackst_q <= sda_s_q;
    end
  end

  // bus condition and interrupt flags
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      beg_flag_q  <= 1'b0;
      halt_flag_q <= 1'b0;
      irq_q       <= 1'b0;
      arb_q       <= 1'b0;
    end else if (!enabled) begin
      beg_flag_q  <= 1'b0;
      halt_flag_q <= 1'b0;
      irq_q       <= 1'b0;
      arb_q       <= 1'b0;
    end else begin
      if (start_seen) begin
        beg_flag_q  <= 1'b1;
        halt_flag_q <= 1'b0;
      end else if (stop_seen) begin
        beg_flag_q  <= 1'b0;
        halt_flag_q <= 1'b1;
      end
      // hardware set wins over software clear
      if (tx_ack_done || rx_done || seq_done || stop_seen && !busy)
        irq_q <= 1'b1;
      else if (wr && wb_adr_i == ADR_STATUS && !wb_dat_i[ST_IRQ_FLAG])
        irq_q <= 1'b0;
      if (sda_miss)
        arb_q <= 1'b1;
      else if (wr && wb_adr_i == ADR_STATUS && !wb_dat_i[ST_ARB_LOSS])
        arb_q <= 1'b0;
    end
  end

  // open drain pins, oe low drives low
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sda_oe_b <= 1'b1;
      scl_oe_b <= 1'b1;
      irq_flag <= 1'b0;
    end else begin
      sda_oe_b <= !(sda_low_q && enabled && !arb_q);
      scl_oe_b <= !(scl_low_q && enabled && !arb_q);
      irq_flag <= irq_q;
    end
  end
  assign sda_o = 1'b0;
  assign scl_o = 1'b0;
endmodule // i2c_host_engine

// File: verilog/i2c_host_pkg.sv
package i2c_host_pkg;

  // wishbone register offsets (byte addresses)
  localparam logic [7:0] ADR_BUFFER  = 8'h00;
  localparam logic [7:0] ADR_RELOAD  = 8'h04;
  localparam logic [7:0] ADR_CONTROL = 8'h08;
  localparam logic [7:0] ADR_STATUS  = 8'h0C;

  // control register fields
  localparam int CTL_BEGIN   = 0;
  localparam int CTL_REPEAT  = 1;
  localparam int CTL_HALT    = 2;
  localparam int CTL_RECEIVE = 3;
  localparam int CTL_ACKSEQ  = 4;
  localparam int CTL_ACKDATA = 5;
  localparam int CTL_ENABLE  = 7;

  // status register fields
  localparam int ST_BUFFER_FULL = 0;
  localparam int ST_BEGIN_FLAG  = 1;
  localparam int ST_HALT_FLAG   = 2;
  localparam int ST_ACK_STATUS  = 3;
  localparam int ST_OVERRUN     = 4;
  localparam int ST_WRITE_CLASH = 5;
  localparam int ST_IRQ_FLAG    = 6;
  localparam int ST_ARB_LOSS    = 7;

  localparam logic [7:0] RELOAD_RESET = 8'h09;
  localparam logic [7:0] BYTE_ZERO    = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [4:0] {
    ST_IDLE, ST_BEG_WAIT, ST_BEG_HOLD,
    ST_RPT_LOW, ST_RPT_SDAHI, ST_RPT_SCLHI, ST_RPT_HOLD, ST_RPT_END,
    ST_TX_LOW, ST_TX_HIGH, ST_ACKIN_LOW, ST_ACKIN_HIGH,
    ST_RX_LOW, ST_RX_HIGH,
    ST_ACK_LOW, ST_ACK_HIGH,
    ST_HALT_SDA, ST_HALT_SCL, ST_HALT_REL, ST_HALT_END
  } engine_state_e;

endpackage

// File: verilog/rate_if.sv
`timescale 1ns/10ps
interface rate_if;
  logic       run;
  logic       reload;
  logic [7:0] reload_value;
  logic       tick;
  modport ctrl (output run, output reload, output reload_value, input tick);
  modport div  (input run, input reload, input reload_value, output tick);
endinterface // rate_if

// File: verilog/rate_divider.sv
`timescale 1ns/10ps
module rate_divider (
  input  wire logic sys_clk,
  input  wire logic rst_b,
  rate_if.div       rate
);
  import i2c_host_pkg::*;

  logic [7:0] count_q;
  logic       tick_q;

  // down counter, one tick pulse per rollover
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= BYTE_ZERO;
      tick_q  <= 1'b0;
    end else if (rate.reload || !rate.run) begin
      count_q <= rate.reload_value;
      tick_q  <= 1'b0;
    end else if (count_q == BYTE_ZERO) begin
      count_q <= rate.reload_value;
      tick_q  <= 1'b1;
    end else begin
      count_q <= count_q - 8'h01;
      tick_q  <= 1'b0;
    end
  end

  assign rate.tick = tick_q;
endmodule // rate_divider

// File: verif/i2c_host_engine_properties.sv
`timescale 1ns/10ps
module i2c_host_engine_properties (
  input wire logic        sys_clk,
  input wire logic        rst_b,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        sda_i,
  input wire logic        sda_o,
  input wire logic        sda_oe_b,
  input wire logic        scl_i,
  input wire logic        scl_o,
  input wire logic        scl_oe_b,
  input wire logic        irq_flag
);
  import i2c_host_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  chk_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  chk_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_has_req: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  chk_unmapped_reads_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h10 |-> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_lines_open_drain: assert property (!sda_o && !scl_o)
    else $error("pin driven high");
  chk_quiet_after_reset: assert property (!$past(rst_b) |-> sda_oe_b && scl_oe_b && !irq_flag)
    else $error("lines or irq active after reset");
  chk_scl_low_phase: assert property ($fell(scl_oe_b) |-> !scl_oe_b [*4])
    else $error("scl low phase too short");
  chk_scl_high_phase: assert property ($rose(scl_oe_b) |-> scl_oe_b [*4])
    else $error("scl high phase too short");
endmodule // i2c_host_engine_properties

// File: verif/i2c_client_model.sv
`timescale 1ns/10ps
module i2c_client_model (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       nack,
  input  wire logic       send_en,
  input  wire logic [7:0] send_byte,
  input  wire logic       grab,
  output logic            sda_drv_b
);
  logic [3:0] bit_q;
  logic       own_b;
  initial begin
    bit_q = 4'h0;
    own_b = 1'b1;
  end
  // a start on the wire restarts the count
  always @(negedge sda) begin
    if (scl) bit_q = 4'h0;
  end
  always @(posedge scl) begin
    bit_q = (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
  end
  // sda changes while scl is low, or at once when send_en rises
  always @(negedge scl or posedge send_en) begin
    if (send_en && bit_q < 4'h8) own_b = send_byte[3'h7 - bit_q[2:0]];
    else if (!send_en && bit_q == 4'h8) own_b = nack;
    else own_b = 1'b1;
  end
  // grab plays a second host pulling sda low
  assign sda_drv_b = own_b & !grab;
endmodule // i2c_client_model

// File: verif/i2c_host_engine_tb.sv
`timescale 1ns/10ps
module i2c_host_engine_tb;
  import i2c_host_pkg::*;
  logic        sys_clk, rst_b, wb_cyc_i, wb_stb_i, wb_we_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic        wb_ack_o, sda_o, sda_oe_b, scl_o, scl_oe_b, irq_flag;
  logic        nack, send_en, grab, drv_b;
  logic [7:0]  send_byte, q;
  logic [8:0]  cap;
  int          miscompares, cmp_count, cycles;
  wire         sda = sda_oe_b & drv_b;
  wire         scl = scl_oe_b;

  i2c_host_engine DUT (.sys_clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .sda_i(sda), .sda_o, .sda_oe_b, .scl_i(scl), .scl_o, .scl_oe_b, .irq_flag);
  i2c_client_model client (.scl, .sda, .nack, .send_en, .send_byte, .grab, .sda_drv_b(drv_b));

  always @(posedge scl) cap <= {cap[7:0], sda};
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      final_report();
    end
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h00_0000, d};
    do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task wait_st(input int b, input logic v);
    int n;
    n = 0;
    do begin
      wb(1'b0, ADR_STATUS, 8'h00);
      n++;
    end while (q[b] !== v && n < 400);
    check(q[b], v);
  endtask
  task t_reset;
    wb(1'b0, ADR_RELOAD, 8'h00);
    check(q, 8'h09);
    wb(1'b0, ADR_STATUS, 8'h00);
    check(q, 8'h00);
    check({sda_oe_b, scl_oe_b, irq_flag}, 3'b110);
    wb(1'b0, 8'h10, 8'h00);
    check(q, 8'h00);
    $display("t_reset done");
  endtask
  task t_start;
    wb(1'b1, ADR_RELOAD, 8'h03);
    wb(1'b1, ADR_BUFFER, 8'hA5);
    wait_st(ST_WRITE_CLASH, 1'b1);
    wb(1'b1, ADR_STATUS, 8'h00);
    wb(1'b1, ADR_CONTROL, 8'h80);
    wb(1'b0, ADR_STATUS, 8'h00);
    check(q[2:1], 2'b00);
    wb(1'b1, ADR_CONTROL, 8'h81);
    wait_st(ST_IRQ_FLAG, 1'b1);
    wait_st(ST_BEGIN_FLAG, 1'b1);
    wb(1'b0, ADR_CONTROL, 8'h00);
    check(q, 8'h80);
    check({sda_oe_b, scl_oe_b}, 2'b00);
    $display("t_start done");
  endtask
  task t_tx(input logic [7:0] d, input logic nk);
    nack <= nk;
    wb(1'b1, ADR_STATUS, 8'h00);
    wb(1'b1, ADR_BUFFER, d);
    wb(1'b1, ADR_CONTROL, 8'h88);
    wait_st(ST_IRQ_FLAG, 1'b1);
    check(cap, {d, nk});
    check(q[ST_ACK_STATUS], nk);
    check(scl_oe_b, 1'b0);
    wb(1'b0, ADR_CONTROL, 8'h00);
    check(q, 8'h80);
    $display("t_tx done");
  endtask
  task t_rx;
    send_byte <= 8'hC3;
    send_en <= 1'b1;
    repeat (2) begin
      wb(1'b1, ADR_STATUS, 8'h00);
      wb(1'b1, ADR_CONTROL, 8'h88);
      wb(1'b1, ADR_BUFFER, 8'h11);
      wait_st(ST_IRQ_FLAG, 1'b1);
      check(q & 8'h61, 8'h61);
      check(cap[7:0], 8'hC3);
      check(scl_oe_b, 1'b0);
      wb(1'b0, ADR_CONTROL, 8'h00);
      check(q, 8'h80);
      // host acks so the client moves on to its next byte
      wb(1'b1, ADR_CONTROL, 8'h90);
      do wb(1'b0, ADR_CONTROL, 8'h00); while (q[CTL_ACKSEQ] !== 1'b0);
    end
    check(q[ST_OVERRUN], 1'b0);
    wait_st(ST_OVERRUN, 1'b1);
    wb(1'b0, ADR_BUFFER, 8'h00);
    check(q, 8'hC3);
    wait_st(ST_BUFFER_FULL, 1'b0);
    send_en <= 1'b0;
    $display("t_rx done");
  endtask
  task t_ack;
    wb(1'b1, ADR_CONTROL, 8'hB0);
    do wb(1'b0, ADR_CONTROL, 8'h00); while (q[CTL_ACKSEQ] !== 1'b0);
    check(cap[0], 1'b1);
    check(scl_oe_b, 1'b0);
    $display("t_ack done");
  endtask
  task t_stop;
    wb(1'b1, ADR_STATUS, 8'h00);
    wb(1'b1, ADR_CONTROL, 8'h84);
    wait_st(ST_IRQ_FLAG, 1'b1);
    check(q[ST_HALT_FLAG], 1'b1);
    wb(1'b0, ADR_CONTROL, 8'h00);
    check(q, 8'h80);
    check({sda_oe_b, scl_oe_b}, 2'b11);
    wb(1'b1, ADR_CONTROL, 8'h00);
    wait_st(ST_HALT_FLAG, 1'b0);
    wb(1'b1, ADR_CONTROL, 8'h80);
    $display("t_stop done");
  endtask
  task t_loss;
    wb(1'b1, ADR_CONTROL, 8'h81);
    wait_st(ST_IRQ_FLAG, 1'b1);
    wb(1'b1, ADR_STATUS, 8'h00);
    wb(1'b1, ADR_BUFFER, 8'hFF);
    grab <= 1'b1;
    wait_st(ST_ARB_LOSS, 1'b1);
    check(q[ST_BUFFER_FULL], 1'b0);
    check({sda_oe_b, scl_oe_b}, 2'b11);
    wb(1'b0, ADR_CONTROL, 8'h00);
    check(q, 8'h80);
    wb(1'b1, ADR_STATUS, 8'h00);
    grab <= 1'b0;
    wait_st(ST_IRQ_FLAG, 1'b1);
    check(q[ST_HALT_FLAG], 1'b1);
    wb(1'b1, ADR_STATUS, 8'h00);
    wb(1'b1, ADR_CONTROL, 8'h81);
    wait_st(ST_IRQ_FLAG, 1'b1);
    t_tx(8'h5A, 1'b0);
    $display("t_loss done");
  endtask
  task t_midreset;
    wb(1'b1, ADR_BUFFER, 8'h00);
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    check({sda_oe_b, scl_oe_b}, 2'b11);
    wb(1'b0, ADR_CONTROL, 8'h00);
    check(q, 8'h00);
    wb(1'b0, ADR_STATUS, 8'h00);
    check(q, 8'h00);
    $display("t_midreset done");
  endtask
  task final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    {rst_b, wb_cyc_i, wb_stb_i, wb_we_i, nack, send_en, grab} = 7'h00;
    {wb_adr_i, send_byte, cap} = 25'h000_0000;
    wb_sel_i = 4'h1;
    wb_dat_i = 32'h0000_0000;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_reset();
    t_start();
    t_tx(8'hA5, 1'b0);
    t_tx(8'h3C, 1'b1);
    t_rx();
    t_ack();
    t_stop();
    t_loss();
    t_midreset();
    final_report();
  end
endmodule // i2c_host_engine_tb

bind i2c_host_engine i2c_host_engine_properties u_props (.sys_clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .sda_i, .sda_o, .sda_oe_b, .scl_i, .scl_o,
  .scl_oe_b, .irq_flag);
